/* File: hw/enclosure_mgmt_defines.vh */
// Register offsets, field positions, reset values and timing counts
`ifndef ENCLOSURE_MGMT_DEFINES_VH
`define ENCLOSURE_MGMT_DEFINES_VH

// Byte offsets on the register bus
`define EMC_OFS_CTL_STS      8'h20
`define EMC_OFS_EXT_CAPS     8'h24
`define EMC_OFS_HANDOFF      8'h28
`define EMC_OFS_INT_STATUS   8'h40
`define EMC_OFS_INT_CLEAR    8'h44
`define EMC_OFS_INT_ENABLE   8'h48

// Control/status field positions
`define EMC_BIT_GPIO_STYLE   19
`define EMC_BIT_SCSI_ENCL    18
`define EMC_BIT_FT_ENCL      17
`define EMC_BIT_INDICATOR    16
`define EMC_BIT_RESET_REQ    9
`define EMC_BIT_TRANSMIT     8
`define EMC_BIT_MSG_RCVD     0

// Extended capability field position
`define EMC_BIT_HANDOFF_CAP  0

// Ownership handoff register layout
`define EMC_HO_BIOS_OWNED    0
`define EMC_HO_OS_OWNED      1
`define EMC_HO_SMI_EN        2
`define EMC_HO_OWN_CHANGE    3
`define EMC_HO_BIOS_BUSY     4
`define EMC_HO_MASK          32'h0000001f

// Interrupt status layout
`define EMC_IRQ_TX_DONE      0
`define EMC_IRQ_RX_DONE      1
`define EMC_IRQ_RST_DONE     2
`define EMC_IRQ_WIDTH        3

// Reset values
`define EMC_RST_ZERO         32'h00000000
`define EMC_RST_IRQ          3'h0

// Enclosure reset pulse: time in ns and derived cycles at clock rate
`define EMC_CLK_PERIOD_NS    20
`define EMC_ENCL_RST_NS      200
`define EMC_ENCL_RST_CYC     ((`EMC_ENCL_RST_NS + `EMC_CLK_PERIOD_NS - 1) / `EMC_CLK_PERIOD_NS)

`endif

/* File: hw/enclosure_pulse_timer.v */
// Fixed-length pulse timer for the enclosure reset sequence
`timescale 1ns/1ns
`include "enclosure_mgmt_defines.vh"
module enclosure_pulse_timer
(
   input  wire       clock,
   input  wire       srst,
   input  wire       start,
   output wire       busy,
   output reg        done
);

   localparam [31:0] LOAD_WIDE  = `EMC_ENCL_RST_CYC;
   localparam [7:0]  LOAD_VALUE = LOAD_WIDE[7:0];

   reg [7:0] count_q;

   assign busy = (count_q != 8'h00);

   always @(posedge clock)
   begin
      if (srst)
      begin
         count_q <= 8'h00;
         done    <= 1'b0;
      end
      else
      begin
         done <= 1'b0;
         if (start && !busy)
         begin
            count_q <= LOAD_VALUE;
         end
         else if (busy)
         begin
            count_q <= count_q - 8'h01;
            if (count_q == 8'h01)
            begin
               done <= 1'b1;
            end
         end
      end
   end

endmodule

/* File: hw/enclosure_mgmt_ctl_caps.v */
// Enclosure message control/status and extended capability registers
//
// What this block does
// - Bit 19 reads the fixed gpio-style message support strap.
// - Bit 18 reads the fixed scsi enclosure message support strap.
// - Bit 17 reads the fixed fault tolerant enclosure message strap.
// - Bit 16 reads the fixed indicator message support strap.
// - Writing one to bit 9 resets the message logic and the processor.
// - Bit 9 self-clears when the reset finishes; writing zero is ignored.
// - Writing one to bit 8 sends the buffered message to the enclosure.
// - Bit 8 clears once the whole message is sent, or when an enclosure reset aborts a launched send; zero is ignored.
// - Bit 0 sets when an incoming message is fully in the buffer.
// - Writing one to bit 0 clears it and writing zero does nothing.
// - Bit 0 at offset 24h reads the fixed handoff capability strap.
// - The handoff register exists only when the capability reads one.
// - The hardware activity signal waits for a first transmit request.
//
// Design decision made here: the Avalon-MM register port.
`timescale 1ns/1ns
`include "enclosure_mgmt_defines.vh"
module enclosure_mgmt_ctl_caps
#(
   parameter GPIO_STYLE_SUPPORTED  = 1'b1,
   parameter SCSI_ENCL_SUPPORTED   = 1'b0,
   parameter FT_ENCL_SUPPORTED     = 1'b0,
   parameter INDICATOR_SUPPORTED   = 1'b1,
   parameter HANDOFF_CAPABLE       = 1'b1,
   parameter HW_ACTIVITY_INDICATOR = 1'b1
)
(
   input  wire        clock,
   input  wire        srst,
   // Avalon-MM slave
   input  wire [7:0]  avs_address,
   input  wire        avs_read,
   input  wire        avs_write,
   input  wire [31:0] avs_writedata,
   input  wire [3:0]  avs_byteenable,
   output reg  [31:0] avs_readdata,
   output wire        avs_waitrequest,
   output reg  [1:0]  avs_response,
   // Enclosure side
   output reg         encl_reset,
   output reg         tx_start,
   input  wire        tx_done,
   input  wire        rx_complete,
   input  wire        activity_in,
   output reg         activity_out,
   output wire        message_logic_reset,
   output wire        irq
);

   // -----------------------------------------------------------------
   // Bus handshake
   // -----------------------------------------------------------------
   // One wait state: the access completes in the cycle after it rises,
   // which keeps read data registered and side effects single-shot.
   localparam [1:0] RESP_OK     = 2'b00;
   localparam [1:0] RESP_DECERR = 2'b11;

   reg  ack_q;
   wire access;
   wire take;
   wire wr_take;
   wire rd_take;

   assign access          = avs_read | avs_write;
   assign avs_waitrequest = access & ~ack_q;
   assign take            = access & ack_q;
   assign wr_take         = take & avs_write;
   assign rd_take         = take & avs_read;

   always @(posedge clock)
   begin
      if (srst)
      begin
         ack_q <= 1'b0;
      end
      else
      begin
         ack_q <= access & ~ack_q;
      end
   end

   // -----------------------------------------------------------------
   // Address decode
   // -----------------------------------------------------------------
   reg hit_ctl;
   reg hit_caps;
   reg hit_ho;
   reg hit_ist;
   reg hit_icl;
   reg hit_ien;
   reg hit_any;

   always @*
   begin
      hit_ctl  = 1'b0;
      hit_caps = 1'b0;
      hit_ho   = 1'b0;
      hit_ist  = 1'b0;
      hit_icl  = 1'b0;
      hit_ien  = 1'b0;
      if (avs_address == `EMC_OFS_CTL_STS)
         hit_ctl = 1'b1;
      else if (avs_address == `EMC_OFS_EXT_CAPS)
         hit_caps = 1'b1;
      else if (avs_address == `EMC_OFS_HANDOFF && HANDOFF_CAPABLE)
         hit_ho = 1'b1;
      else if (avs_address == `EMC_OFS_INT_STATUS)
         hit_ist = 1'b1;
      else if (avs_address == `EMC_OFS_INT_CLEAR)
         hit_icl = 1'b1;
      else if (avs_address == `EMC_OFS_INT_ENABLE)
         hit_ien = 1'b1;
      hit_any = hit_ctl | hit_caps | hit_ho | hit_ist | hit_icl | hit_ien;
   end

   // Byte-lane qualified write data; lanes not enabled write as zero
   wire [31:0] wmask;
   wire [31:0] wdata;

   assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                   {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
   assign wdata = avs_writedata & wmask;

   // -----------------------------------------------------------------
   // Enclosure reset sequence
   // -----------------------------------------------------------------
   reg  reset_req_q;
   reg  reset_start_q;
   wire timer_busy;
   wire timer_done;

   enclosure_pulse_timer u_timer
   (
      .clock (clock),
      .srst  (srst),
      .start (reset_start_q),
      .busy  (timer_busy),
      .done  (timer_done)
   );

   // Message logic is held in reset while the request bit stands
   assign message_logic_reset = reset_req_q;

   always @(posedge clock)
   begin
      if (srst)
      begin
         reset_req_q   <= 1'b0;
         reset_start_q <= 1'b0;
         encl_reset    <= 1'b0;
      end
      else
      begin
         reset_start_q <= 1'b0;
         if (wr_take && hit_ctl && wdata[`EMC_BIT_RESET_REQ] && !reset_req_q)
         begin
            reset_req_q   <= 1'b1;
            reset_start_q <= 1'b1;
         end
         else if (timer_done)
         begin
            reset_req_q <= 1'b0;
         end
         encl_reset <= reset_start_q | timer_busy;
      end
   end

   // -----------------------------------------------------------------
   // Transmit request
   // -----------------------------------------------------------------
   // A transmit written during enclosure reset is still honoured; it is
   // launched once the reset finishes so the request is never lost.
   reg transmit_q;
   reg tx_launched_q;
   reg tx_seen_q;

   always @(posedge clock)
   begin
      if (srst)
      begin
         transmit_q    <= 1'b0;
         tx_launched_q <= 1'b0;
         tx_start      <= 1'b0;
         tx_seen_q     <= 1'b0;
      end
      else
      begin
         tx_start <= 1'b0;
         if (reset_req_q && !timer_done)
         begin
            tx_launched_q <= 1'b0;
            if (wr_take && hit_ctl && wdata[`EMC_BIT_TRANSMIT])
               transmit_q <= 1'b1;
            else if (tx_launched_q)
               transmit_q <= 1'b0;
         end
         else if (transmit_q && !tx_launched_q)
         begin
            tx_start      <= 1'b1;
            tx_launched_q <= 1'b1;
         end
         else if (transmit_q && tx_done)
         begin
            transmit_q    <= 1'b0;
            tx_launched_q <= 1'b0;
         end
         else if (wr_take && hit_ctl && wdata[`EMC_BIT_TRANSMIT])
         begin
            transmit_q <= 1'b1;
         end
         if (wr_take && hit_ctl && wdata[`EMC_BIT_TRANSMIT])
            tx_seen_q <= 1'b1;
         if (reset_req_q)
            tx_seen_q <= 1'b0;
      end
   end

   // -----------------------------------------------------------------
   // Hardware activity indicator
   // -----------------------------------------------------------------
   always @(posedge clock)
   begin
      if (srst)
         activity_out <= 1'b0;
      else
         activity_out <= HW_ACTIVITY_INDICATOR & tx_seen_q & activity_in;
   end

   // -----------------------------------------------------------------
   // Message received flag
   // -----------------------------------------------------------------
   reg msg_rcvd_q;

   always @(posedge clock)
   begin
      if (srst || reset_req_q)
         msg_rcvd_q <= 1'b0;
      else if (rx_complete)
         msg_rcvd_q <= 1'b1;
      else if (wr_take && hit_ctl && wdata[`EMC_BIT_MSG_RCVD])
         msg_rcvd_q <= 1'b0;
   end

   // -----------------------------------------------------------------
   // Ownership handoff register
   // -----------------------------------------------------------------
   // Semaphore bits survive the message reset; only srst clears them.
   reg  [4:0] ho_q;
   wire       os_rise;

   assign os_rise = wr_take && hit_ho && wdata[`EMC_HO_OS_OWNED]
                    && !ho_q[`EMC_HO_OS_OWNED];

   always @(posedge clock)
   begin
      if (srst || !HANDOFF_CAPABLE)
      begin
         ho_q <= 5'h00;
      end
      else
      begin
         if (wr_take && hit_ho)
         begin
            ho_q[`EMC_HO_BIOS_OWNED] <= wdata[`EMC_HO_BIOS_OWNED];
            ho_q[`EMC_HO_OS_OWNED]   <= wdata[`EMC_HO_OS_OWNED];
            ho_q[`EMC_HO_SMI_EN]     <= wdata[`EMC_HO_SMI_EN];
            ho_q[`EMC_HO_BIOS_BUSY]  <= wdata[`EMC_HO_BIOS_BUSY];
         end
         if (os_rise)
            ho_q[`EMC_HO_OWN_CHANGE] <= 1'b1;
         else if (wr_take && hit_ho && wdata[`EMC_HO_OWN_CHANGE])
            ho_q[`EMC_HO_OWN_CHANGE] <= 1'b0;
      end
   end

   // -----------------------------------------------------------------
   // Interrupts
   // -----------------------------------------------------------------
   reg  [`EMC_IRQ_WIDTH-1:0] irq_status_q;
   reg  [`EMC_IRQ_WIDTH-1:0] irq_enable_q;
   wire [`EMC_IRQ_WIDTH-1:0] irq_events;
   wire [`EMC_IRQ_WIDTH-1:0] irq_clear;

   assign irq_events = {timer_done, rx_complete, transmit_q & tx_done};
   assign irq_clear  = (wr_take && hit_icl) ?
                       wdata[`EMC_IRQ_WIDTH-1:0] : `EMC_RST_IRQ;
   assign irq        = |(irq_status_q & irq_enable_q);

   // Set wins over a clear that lands in the same cycle
   always @(posedge clock)
   begin
      if (srst)
      begin
         irq_status_q <= `EMC_RST_IRQ;
         irq_enable_q <= `EMC_RST_IRQ;
      end
      else
      begin
         irq_status_q <= (irq_status_q & ~irq_clear) | irq_events;
         if (wr_take && hit_ien)
            irq_enable_q <= wdata[`EMC_IRQ_WIDTH-1:0];
      end
   end

   // -----------------------------------------------------------------
   // Read data
   // -----------------------------------------------------------------
   reg [31:0] rd_word;

   always @*
   begin
      rd_word = `EMC_RST_ZERO;
      if (hit_ctl)
      begin
         rd_word[`EMC_BIT_GPIO_STYLE] = GPIO_STYLE_SUPPORTED;
         rd_word[`EMC_BIT_SCSI_ENCL]  = SCSI_ENCL_SUPPORTED;
         rd_word[`EMC_BIT_FT_ENCL]    = FT_ENCL_SUPPORTED;
         rd_word[`EMC_BIT_INDICATOR]  = INDICATOR_SUPPORTED;
         rd_word[`EMC_BIT_RESET_REQ]  = reset_req_q;
         rd_word[`EMC_BIT_TRANSMIT]   = transmit_q;
         rd_word[`EMC_BIT_MSG_RCVD]   = msg_rcvd_q;
      end
      else if (hit_caps)
         rd_word[`EMC_BIT_HANDOFF_CAP] = HANDOFF_CAPABLE;
      else if (hit_ho)
         rd_word[4:0] = ho_q;
      else if (hit_ist)
         rd_word[`EMC_IRQ_WIDTH-1:0] = irq_status_q;
      else if (hit_ien)
         rd_word[`EMC_IRQ_WIDTH-1:0] = irq_enable_q;
   end

   always @(posedge clock)
   begin
      if (srst)
      begin
         avs_readdata <= `EMC_RST_ZERO;
         avs_response <= RESP_OK;
      end
      else if (access && !ack_q)
      begin
         avs_readdata <= avs_read ? rd_word : `EMC_RST_ZERO;
         avs_response <= hit_any ? RESP_OK : RESP_DECERR;
      end
   end

endmodule

/* File: test/encl_partner.sv */
// Behavioural enclosure processor facing the control block
`timescale 1ns/1ns
module encl_partner
(
   input  wire  clock,
   input  wire  srst,
   input  wire  encl_reset,
   input  wire  tx_start,
   input  wire  rx_go,
   input  int   tx_delay,
   output logic tx_done = 1'b0,
   output logic rx_complete = 1'b0
);
   // ----------------------
   // Send and receive model
   // ----------------------
   int cnt = 0;
   always @(posedge clock)
   begin
      tx_done <= 1'b0;
      // Frames that arrive during a reset are lost
      rx_complete <= rx_go & ~encl_reset;
      if (srst | encl_reset)
         cnt <= 0;
      else if (tx_start)
         cnt <= tx_delay;
      else if (cnt > 0)
      begin
         cnt <= cnt - 1;
         tx_done <= (cnt == 1);
      end
   end
endmodule

/* File: test/encl_ctl_assertions.sv */
// Port checks for the enclosure control and capability registers
`timescale 1ns/1ns
module encl_ctl_checker
#(
   parameter GPIO_STYLE_SUPPORTED = 1'b1,
   parameter SCSI_ENCL_SUPPORTED  = 1'b0,
   parameter FT_ENCL_SUPPORTED    = 1'b0,
   parameter INDICATOR_SUPPORTED  = 1'b1,
   parameter HANDOFF_CAPABLE      = 1'b1
)
(
   input wire        clock,
   input wire        srst,
   input wire [7:0]  avs_address,
   input wire        avs_read,
   input wire        avs_write,
   input wire [31:0] avs_writedata,
   input wire [3:0]  avs_byteenable,
   input wire [31:0] avs_readdata,
   input wire        avs_waitrequest,
   input wire [1:0]  avs_response,
   input wire        encl_reset,
   input wire        tx_start,
   input wire        activity_out,
   input wire        message_logic_reset
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);
   // ------------
   // Helper logic
   // ------------
   wire       req    = avs_read | avs_write;
   wire       rd_ok  = avs_read & ~avs_waitrequest;
   wire       wr_ctl = avs_write & ~avs_waitrequest & avs_byteenable[1]
                       & (avs_address == 8'h20);
   wire [3:0] straps = {GPIO_STYLE_SUPPORTED, SCSI_ENCL_SUPPORTED,
                        FT_ENCL_SUPPORTED, INDICATOR_SUPPORTED};
   reg        armed_q;
   // Only the first transmit after a full reset is tracked, so the
   // re-arm on an enclosure reset is left to the bench
   always @(posedge clock)
      if (srst)
         armed_q <= 1'b0;
      else if (wr_ctl & avs_writedata[8])
         armed_q <= 1'b1;
   // ----------
   // Properties
   // ----------
   property p_one_wait;
      req && !$past(req) |-> avs_waitrequest ##1 !avs_waitrequest;
   endproperty
   a_one_wait: assert property (p_one_wait)
      else $error("access not answered after one wait state");
   property p_straps;
      rd_ok && avs_address == 8'h20 |-> avs_readdata[19:16] == straps;
   endproperty
   a_straps: assert property (p_straps)
      else $error("support flags differ from straps");
   property p_reserved;
      rd_ok && avs_address == 8'h20 |-> avs_readdata[31:20] == 12'h000
         && avs_readdata[15:10] == 6'h00 && avs_readdata[7:1] == 7'h00;
   endproperty
   a_reserved: assert property (p_reserved)
      else $error("reserved control bits not zero");
   property p_caps;
      rd_ok && avs_address == 8'h24 |->
         avs_readdata == (HANDOFF_CAPABLE ? 32'h1 : 32'h0);
   endproperty
   a_caps: assert property (p_caps)
      else $error("capability word wrong");
   property p_handoff;
      rd_ok && avs_address == 8'h28 |->
         avs_response == (HANDOFF_CAPABLE ? 2'b00 : 2'b11);
   endproperty
   a_handoff: assert property (p_handoff)
      else $error("handoff register presence wrong");
   property p_rst_launch;
      wr_ctl && avs_writedata[9] |=> message_logic_reset ##[0:3] encl_reset;
   endproperty
   a_rst_launch: assert property (p_rst_launch)
      else $error("enclosure reset not started");
   property p_rst_pulse;
      $rose(encl_reset) |-> encl_reset[*8] ##[1:20] !encl_reset;
   endproperty
   a_rst_pulse: assert property (p_rst_pulse)
      else $error("enclosure reset pulse length wrong");
   property p_tx_launch;
      wr_ctl && avs_writedata[8] && !message_logic_reset |->
         ##[1:3] tx_start ##1 !tx_start;
   endproperty
   a_tx_launch: assert property (p_tx_launch)
      else $error("transmit pulse missing or too long");
   property p_activity;
      !armed_q |-> !activity_out;
   endproperty
   a_activity: assert property (p_activity)
      else $error("activity output before first transmit");
endmodule

bind enclosure_mgmt_ctl_caps encl_ctl_checker
#(
   .GPIO_STYLE_SUPPORTED (GPIO_STYLE_SUPPORTED),
   .SCSI_ENCL_SUPPORTED  (SCSI_ENCL_SUPPORTED),
   .FT_ENCL_SUPPORTED    (FT_ENCL_SUPPORTED),
   .INDICATOR_SUPPORTED  (INDICATOR_SUPPORTED),
   .HANDOFF_CAPABLE      (HANDOFF_CAPABLE)
)
chk
(
   .clock(clock), .srst(srst), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .avs_response(avs_response), .encl_reset(encl_reset),
   .tx_start(tx_start), .activity_out(activity_out),
   .message_logic_reset(message_logic_reset)
);

/* File: test/tb_top.sv */
// Self-checking bench for the enclosure control and capability block
`timescale 1ns/1ns
module tb_top;
   localparam logic [31:0] CTL0 = 32'h000a0000;
   typedef struct {logic [7:0] a; logic [31:0] d; logic [1:0] r;} row_t;
   logic        clock = 1'b0;
   logic        srst = 1'b1;
   logic [7:0]  avs_address = 8'h00;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h00000000;
   logic [3:0]  avs_byteenable = 4'hf;
   logic        activity_in = 1'b1;
   logic        rx_go = 1'b0;
   wire  [31:0] avs_readdata;
   wire         avs_waitrequest;
   wire  [1:0]  avs_response;
   wire         encl_reset, tx_start, tx_done, rx_complete;
   wire         activity_out, message_logic_reset, irq;
   logic [31:0] rd;
   logic [1:0]  rsp;
   int          tx_delay = 20;
   int          error_cnt = 0;
   int          check_count = 0;
   row_t        rows [6];

   always #10 clock = ~clock;

   enclosure_mgmt_ctl_caps #(.GPIO_STYLE_SUPPORTED(1'b1),
      .SCSI_ENCL_SUPPORTED(1'b0), .FT_ENCL_SUPPORTED(1'b1),
      .INDICATOR_SUPPORTED(1'b0), .HANDOFF_CAPABLE(1'b1)) uut
   (
      .clock(clock), .srst(srst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .avs_response(avs_response), .encl_reset(encl_reset),
      .tx_start(tx_start), .tx_done(tx_done), .rx_complete(rx_complete),
      .activity_in(activity_in), .activity_out(activity_out),
      .message_logic_reset(message_logic_reset), .irq(irq)
   );

   encl_partner far_end
   (
      .clock(clock), .srst(srst), .encl_reset(encl_reset),
      .tx_start(tx_start), .rx_go(rx_go), .tx_delay(tx_delay),
      .tx_done(tx_done), .rx_complete(rx_complete)
   );

   // -----
   // Tasks
   // -----
   task test_done;
      $display("Checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      check_count++;
      if (g !== e)
      begin
         $display("Error %s expected %h seen %h", nm, e, g);
         error_cnt++;
      end
   endtask

   // Request held until the edge that samples waitrequest low
   task automatic bus(input logic we, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge clock);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= we;
      avs_read <= ~we;
      for (n = 0; n < 20; n++)
      begin
         @(posedge clock);
         if (avs_waitrequest === 1'b0)
            break;
      end
      if (n == 20)
      begin
         chk("waitrequest", 32'h0, 32'h1);
         test_done;
      end
      // Data and response are taken at the edge that ends the wait
      rd = avs_readdata;
      rsp = avs_response;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      // Outputs are looked at once the write has settled
      @(negedge clock);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk("readdata", e, rd);
   endtask

   task automatic wait_clear(input int b);
      int n;
      for (n = 0; n < 40; n++)
      begin
         bus(1'b0, 8'h20, 32'h0);
         if (rd[b] === 1'b0)
         begin
            check_count++;
            return;
         end
      end
      chk("self clearing bit", 32'h0, 32'h1);
      test_done;
   endtask

   task automatic rx_pulse;
      @(posedge clock);
      rx_go <= 1'b1;
      @(posedge clock);
      rx_go <= 1'b0;
   endtask

   // ---------------
   // Main sequence
   // ---------------
   initial
   begin
      rows = '{'{8'h20, CTL0, 2'b00}, '{8'h24, 32'h1, 2'b00},
               '{8'h28, 32'h0, 2'b00}, '{8'h40, 32'h0, 2'b00},
               '{8'h48, 32'h0, 2'b00}, '{8'h80, 32'h0, 2'b11}};
      repeat (3) @(posedge clock);
      srst <= 1'b0;
      foreach (rows[i])
      begin
         rd_chk(rows[i].a, rows[i].d);
         chk("response", {30'h0, rows[i].r}, {30'h0, rsp});
      end
      chk("activity_out", 32'h0, activity_out);
      bus(1'b1, 8'h20, 32'hfffffcfe);
      rd_chk(8'h20, CTL0);
      bus(1'b1, 8'h24, 32'hffffffff);
      rd_chk(8'h24, 32'h1);
      bus(1'b1, 8'h48, 32'h7);
      // Slow far end: the busy bit must stay up for the whole send
      bus(1'b1, 8'h20, 32'h100);
      rd_chk(8'h20, CTL0 | 32'h100);
      wait_clear(8);
      chk("activity_out", 32'h1, activity_out);
      chk("irq", 32'h1, irq);
      rd_chk(8'h40, 32'h1);
      bus(1'b1, 8'h44, 32'h1);
      chk("irq", 32'h0, irq);
      rx_pulse();
      rd_chk(8'h20, CTL0 | 32'h1);
      bus(1'b1, 8'h20, 32'h0);
      rd_chk(8'h20, CTL0 | 32'h1);
      bus(1'b1, 8'h48, 32'h0);
      chk("irq", 32'h0, irq);
      rd_chk(8'h40, 32'h2);
      bus(1'b1, 8'h48, 32'h7);
      chk("irq", 32'h1, irq);
      bus(1'b1, 8'h20, 32'h1);
      rd_chk(8'h20, CTL0);
      bus(1'b1, 8'h44, 32'h7);
      // Back-to-back sends against a prompt far end
      tx_delay = 1;
      bus(1'b1, 8'h20, 32'h100);
      wait_clear(8);
      bus(1'b1, 8'h20, 32'h100);
      wait_clear(8);
      // Enclosure reset in mid-send with a message pending
      tx_delay = 40;
      rx_pulse();
      bus(1'b1, 8'h20, 32'h100);
      bus(1'b1, 8'h20, 32'h200);
      chk("message_logic_reset", 32'h1, message_logic_reset);
      // Pulse to the far end starts one cycle after the bit
      @(negedge clock);
      chk("encl_reset", 32'h1, encl_reset);
      wait_clear(9);
      rd_chk(8'h20, CTL0);
      chk("activity_out", 32'h0, activity_out);
      rd_chk(8'h40, 32'h7);
      bus(1'b1, 8'h28, 32'h2);
      rd_chk(8'h28, 32'ha);
      // Second system reset in mid-run clears every flag
      @(posedge clock);
      srst <= 1'b1;
      repeat (3) @(posedge clock);
      srst <= 1'b0;
      rd_chk(8'h40, 32'h0);
      rd_chk(8'h28, 32'h0);
      rd_chk(8'h20, CTL0);
      chk("activity_out", 32'h0, activity_out);
      test_done;
   end
endmodule
